// ==== common/sac_pkg.sv ====
// constants and carrier types for the converter serial control block
package sac_pkg;
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// control word layout
	// ************************************************************
	localparam int CTRL_BITS    = 8;
	localparam int START_POS    = 7;
	localparam int CH_HI        = 6;
	localparam int CH_LO        = 4;
	localparam int SGL_POS      = 2;
	localparam int MODE_HI      = 1;
	localparam int MODE_LO      = 0;
	localparam int RES_BITS     = 16;
	localparam int CNT_W        = 5;

	// bit counts after the start marker
	localparam logic [CNT_W-1:0] CNT_ACQ      = 5'h03;
	localparam logic [CNT_W-1:0] CNT_WORD_END = 5'h06;
	localparam logic [CNT_W-1:0] CNT_CONV_END = 5'h0F;
	localparam logic [CNT_W-1:0] CNT_READ_END = 5'h0E;
	localparam logic [CNT_W-1:0] CNT_ZERO     = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE      = 5'h01;

	// power and clock mode codes
	localparam logic [1:0] MODE_PD   = 2'h0;
	localparam logic [1:0] MODE_RSVD = 2'h1;
	localparam logic [1:0] MODE_INT  = 2'h2;
	localparam logic [1:0] MODE_EXT  = 2'h3;

	// channel select codes
	localparam logic [2:0] CH_SEL_01 = 3'h1;
	localparam logic [2:0] CH_SEL_10 = 3'h5;
	localparam logic [2:0] CH_SEL_23 = 3'h2;
	localparam logic [2:0] CH_SEL_32 = 3'h6;

	// result coding and reset values
	localparam logic [RES_BITS-1:0] SIGN_BIT  = 16'h8000;
	localparam logic [RES_BITS-1:0] RES_ZERO  = 16'h0000;
	localparam logic                EXT_RESET = 1'b1;

	// internal conversion timing
	localparam int MCLK_PERIOD_NS  = 25;
	localparam int INT_CONV_MAX_NS = 8000;
	localparam int INT_STEP_CYC    = INT_CONV_MAX_NS / (MCLK_PERIOD_NS * (RES_BITS + 1));
	localparam int STEP_W          = 8;

	typedef struct packed {
		logic [3:0] pos;
		logic [3:0] neg;
		logic       com_neg;
	} sac_mux_t;

	typedef enum logic [5:0] {
		L_IDLE = 6'h01,
		L_CTRL = 6'h02,
		L_CONV = 6'h04,
		L_WAIT = 6'h08,
		L_READ = 6'h10,
		L_TAIL = 6'h20
	} sac_lstate_t;

	typedef enum logic [1:0] {
		M_IDLE = 2'h1,
		M_CONV = 2'h2
	} sac_mstate_t;

endpackage

// ==== hdl/sac_serial_ctrl.sv ====
// serial control word decode and conversion sequencing for a four input converter
// What this block does
// - control word begins with its top bit, a one, sent first
// - serial input ignored until a one is seen as start marker
// - word holds start, channel code, unused, input config, mode bits
// - config high: codes 001,101,010,110 pick input 0..3, negative is common
// - config low: differential pairs 0/1, 1/0, 2/3, 3/2 by those codes
// - mode 00 powers down after each conversion, wakes instantly, first valid
// - mode 10 internal clock, 11 external clock always powered, 01 reserved
// - a clock mode change applies only from the following conversion
// - mode 00 keeps the clock mode that was active before it
// - external mode busy high one serial clock after the word ends
// - external mode decisions out on next 16 falling edges, top first
// - next start marker may arrive while the last result bit is out
// - with 32 clocks the final seven clocks shift out zeros
// - external mode busy and output float with chip select high
// - internal mode busy low during conversion, at most 8 us
// - internal result held and readable after completion, unless its word chose mode 11 and chip select rose before the read
// - internal mode top bit on next falling edge, rest on following edges
// - internal mode busy always driven, output floats with chip select high
// - input sampled on rising edges, output changed after falling edges
// - acquisition starts once channel is known, hold three clocks later
// - result is two's complement, sign bit inverted from offset binary
module sac_serial_ctrl (
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire logic               serial_clock_i,
	input  wire logic               cs_n_i,
	input  wire logic               din_i,
	input  wire logic               comparator_i,
	output logic                    dout_o,
	output logic                    dout_oe_o,
	output logic                    busy_o,
	output logic                    busy_oe_o,
	output sac_pkg::sac_mux_t       mux_o,
	output logic                    acquire_o,
	output logic                    hold_o,
	output logic [15:0]             dac_code_o,
	output logic                    low_power_o,
	output logic                    ext_clock_mode_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// state types
	// ************************************************************
	typedef struct packed {
		logic                  rst_s1;
		logic                  rst_s2;
		logic                  done_s1;
		logic                  done_s2;
		logic                  seen;
		sac_pkg::sac_lstate_t  st;
		logic [4:0]            cnt;
		logic [5:0]            ctrl;
		logic                  ext;
		logic                  pd;
		logic                  sgl;
		logic [15:0]           trial;
		logic [15:0]           shreg;
		logic                  outbit;
		logic                  conv_tog;
		logic                  acquire;
		logic                  hold;
		sac_pkg::sac_mux_t     mux;
	} sac_link_t;

	typedef struct packed {
		logic dout;
		logic busy;
	} sac_fall_t;

	typedef struct packed {
		logic                  req_s1;
		logic                  req_s2;
		logic                  req_s3;
		logic                  cmp_s1;
		logic                  cmp_s2;
		sac_pkg::sac_mstate_t  st;
		logic [7:0]            step;
		logic [4:0]            bitc;
		logic [15:0]           trial;
		logic [15:0]           result;
		logic                  done_tog;
	} sac_core_t;

	localparam logic [7:0] STEP_LAST = 8'(sac_pkg::INT_STEP_CYC - 1);

	sac_link_t lr_r;
	sac_link_t ln_nxt;
	sac_fall_t fr_r;
	sac_fall_t fn_nxt;
	sac_core_t mr_r;
	sac_core_t mn_nxt;
	logic      ext_view;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic sac_pkg::sac_mux_t decode_mux(input logic [2:0] ch, input logic sgl);
		sac_pkg::sac_mux_t m;
		m = '0;
		case (ch)
			sac_pkg::CH_SEL_01: begin
				m.pos = 4'h1;
				m.neg = 4'h2;
			end
			sac_pkg::CH_SEL_10: begin
				m.pos = 4'h2;
				m.neg = 4'h1;
			end
			sac_pkg::CH_SEL_23: begin
				m.pos = 4'h4;
				m.neg = 4'h8;
			end
			sac_pkg::CH_SEL_32: begin
				m.pos = 4'h8;
				m.neg = 4'h4;
			end
			default: begin
				m = '0;
			end
		endcase
		if (sgl && m.pos != 4'h0) begin
			m.neg     = 4'h0;
			m.com_neg = 1'b1;
		end
		return m;
	endfunction

	// one successive approximation step on an offset binary trial code
	function automatic logic [15:0] sar_step(input logic [15:0] t, input logic [4:0] k,
		input logic keep);
		logic [15:0] r;
		logic [3:0]  idx;
		r   = t;
		idx = 4'(sac_pkg::RES_BITS - 1) - k[3:0];
		if (!keep) begin
			r[idx] = 1'b0;
		end
		if (idx != 4'h0) begin
			r[idx - 4'h1] = 1'b1;
		end
		return r;
	endfunction

	// ************************************************************
	// link domain, rising serial clock edges
	// ************************************************************
	// chip select is treated as part of the link; its setup to the first rising
	// edge is the host's duty, so it is qualified directly rather than synchronised
	always_comb begin
		logic [7:0] word;
		word            = {1'b1, lr_r.ctrl, din_i};
		ln_nxt          = lr_r;
		ln_nxt.rst_s1   = rst_i;
		ln_nxt.rst_s2   = lr_r.rst_s1;
		ln_nxt.done_s1  = mr_r.done_tog;
		ln_nxt.done_s2  = lr_r.done_s1;
		if (lr_r.rst_s2) begin
			ln_nxt.seen     = lr_r.done_s2;
			ln_nxt.st       = sac_pkg::L_IDLE;
			ln_nxt.cnt      = sac_pkg::CNT_ZERO;
			ln_nxt.ctrl     = '0;
			ln_nxt.ext      = sac_pkg::EXT_RESET;
			ln_nxt.pd       = 1'b0;
			ln_nxt.sgl      = 1'b0;
			ln_nxt.trial    = sac_pkg::SIGN_BIT;
			ln_nxt.shreg    = sac_pkg::RES_ZERO;
			ln_nxt.outbit   = 1'b0;
			ln_nxt.acquire  = 1'b0;
			ln_nxt.hold     = 1'b0;
			ln_nxt.mux      = '0;
			ln_nxt.conv_tog = 1'b0;
		end else if (cs_n_i) begin
			ln_nxt.st       = sac_pkg::L_IDLE;
			ln_nxt.cnt      = sac_pkg::CNT_ZERO;
			ln_nxt.outbit   = 1'b0;
			ln_nxt.acquire  = 1'b0;
			ln_nxt.hold     = 1'b0;
		end else begin
			unique case (lr_r.st)
				sac_pkg::L_IDLE, sac_pkg::L_WAIT: begin
					// a word that switched to external mode still reads its internal result
					if ((lr_r.st == sac_pkg::L_WAIT || !lr_r.ext) &&
						lr_r.done_s2 != lr_r.seen) begin
						ln_nxt.seen   = lr_r.done_s2;
						ln_nxt.outbit = mr_r.result[sac_pkg::RES_BITS-1];
						ln_nxt.shreg  = {mr_r.result[14:0], 1'b0};
						ln_nxt.cnt    = sac_pkg::CNT_ZERO;
						ln_nxt.st     = sac_pkg::L_READ;
					end else if (lr_r.st == sac_pkg::L_IDLE && din_i) begin
						ln_nxt.cnt = sac_pkg::CNT_ZERO;
						ln_nxt.st  = sac_pkg::L_CTRL;
					end
				end
				sac_pkg::L_CTRL: begin
					ln_nxt.ctrl   = {lr_r.ctrl[4:0], din_i};
					ln_nxt.cnt    = lr_r.cnt + sac_pkg::CNT_ONE;
					ln_nxt.outbit = 1'b0;
					if (lr_r.cnt == sac_pkg::CNT_ACQ) begin
						ln_nxt.mux     = decode_mux(lr_r.ctrl[2:0], lr_r.sgl);
						ln_nxt.acquire = 1'b1;
					end
					if (lr_r.cnt == sac_pkg::CNT_WORD_END) begin
						ln_nxt.sgl     = word[sac_pkg::SGL_POS];
						ln_nxt.mux     = decode_mux(word[sac_pkg::CH_HI:sac_pkg::CH_LO],
							word[sac_pkg::SGL_POS]);
						ln_nxt.acquire = 1'b0;
						unique case (word[sac_pkg::MODE_HI:sac_pkg::MODE_LO])
							sac_pkg::MODE_EXT: begin
								ln_nxt.ext = 1'b1;
								ln_nxt.pd  = 1'b0;
							end
							sac_pkg::MODE_INT: begin
								ln_nxt.ext = 1'b0;
								ln_nxt.pd  = 1'b0;
							end
							sac_pkg::MODE_PD: begin
								ln_nxt.pd = 1'b1;
							end
							sac_pkg::MODE_RSVD: begin
								ln_nxt.pd = lr_r.pd;
							end
						endcase
						// this conversion still runs in the mode held before the word
						if (lr_r.ext) begin
							ln_nxt.hold  = 1'b1;
							ln_nxt.trial = sac_pkg::SIGN_BIT;
							ln_nxt.cnt   = sac_pkg::CNT_ZERO;
							ln_nxt.st    = sac_pkg::L_CONV;
						end else begin
							ln_nxt.conv_tog = ~lr_r.conv_tog;
							ln_nxt.st       = sac_pkg::L_WAIT;
						end
					end
				end
				sac_pkg::L_CONV: begin
					ln_nxt.trial  = sar_step(lr_r.trial, lr_r.cnt, comparator_i);
					ln_nxt.outbit = (lr_r.cnt == sac_pkg::CNT_ZERO) ? ~comparator_i
						: comparator_i;
					ln_nxt.cnt    = lr_r.cnt + sac_pkg::CNT_ONE;
					if (lr_r.cnt == sac_pkg::CNT_CONV_END) begin
						ln_nxt.hold = 1'b0;
						ln_nxt.st   = sac_pkg::L_TAIL;
					end
				end
				sac_pkg::L_READ: begin
					ln_nxt.outbit = lr_r.shreg[sac_pkg::RES_BITS-1];
					ln_nxt.shreg  = {lr_r.shreg[14:0], 1'b0};
					ln_nxt.cnt    = lr_r.cnt + sac_pkg::CNT_ONE;
					if (lr_r.cnt == sac_pkg::CNT_READ_END) begin
						ln_nxt.st = sac_pkg::L_TAIL;
					end
				end
				sac_pkg::L_TAIL: begin
					ln_nxt.outbit = 1'b0;
					if (din_i) begin
						ln_nxt.cnt = sac_pkg::CNT_ZERO;
						ln_nxt.st  = sac_pkg::L_CTRL;
					end
				end
			endcase
		end
	end

	always_ff @(posedge serial_clock_i) begin
		lr_r <= ln_nxt;
	end

	// ************************************************************
	// link domain, falling serial clock edges
	// ************************************************************
	always_comb begin
		fn_nxt = fr_r;
		if (lr_r.rst_s2 || cs_n_i) begin
			fn_nxt.dout = 1'b0;
			fn_nxt.busy = 1'b0;
		end else begin
			fn_nxt.dout = lr_r.outbit;
			fn_nxt.busy = (lr_r.st == sac_pkg::L_CONV) &&
				(lr_r.cnt == sac_pkg::CNT_ZERO);
		end
	end

	always_ff @(negedge serial_clock_i) begin
		fr_r <= fn_nxt;
	end

	// ************************************************************
	// internal conversion clock domain
	// ************************************************************
	always_comb begin
		logic last;
		last           = (mr_r.bitc == sac_pkg::CNT_CONV_END);
		mn_nxt         = mr_r;
		mn_nxt.req_s1  = lr_r.conv_tog;
		mn_nxt.req_s2  = mr_r.req_s1;
		mn_nxt.req_s3  = mr_r.req_s2;
		mn_nxt.cmp_s1  = comparator_i;
		mn_nxt.cmp_s2  = mr_r.cmp_s1;
		if (rst_i) begin
			mn_nxt.st       = sac_pkg::M_IDLE;
			mn_nxt.step     = '0;
			mn_nxt.bitc     = sac_pkg::CNT_ZERO;
			mn_nxt.trial    = sac_pkg::SIGN_BIT;
			mn_nxt.result   = sac_pkg::RES_ZERO;
			mn_nxt.done_tog = 1'b0;
		end else begin
			unique case (mr_r.st)
				sac_pkg::M_IDLE: begin
					if (mr_r.req_s2 != mr_r.req_s3) begin
						mn_nxt.st    = sac_pkg::M_CONV;
						mn_nxt.step  = '0;
						mn_nxt.bitc  = sac_pkg::CNT_ZERO;
						mn_nxt.trial = sac_pkg::SIGN_BIT;
					end
				end
				sac_pkg::M_CONV: begin
					mn_nxt.step = mr_r.step + 8'h01;
					if (mr_r.step == STEP_LAST) begin
						mn_nxt.step  = '0;
						mn_nxt.trial = sar_step(mr_r.trial, mr_r.bitc, mr_r.cmp_s2);
						mn_nxt.bitc  = mr_r.bitc + sac_pkg::CNT_ONE;
						if (last) begin
							// result word is stable before the toggle is seen by the link
							mn_nxt.result   = mn_nxt.trial ^ sac_pkg::SIGN_BIT;
							mn_nxt.done_tog = ~mr_r.done_tog;
							mn_nxt.st       = sac_pkg::M_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		mr_r <= mn_nxt;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign dout_o           = fr_r.dout;
	assign dout_oe_o        = ~cs_n_i;
	// busy keeps the style of the clock that runs the conversion, not of the new mode
	assign ext_view         = lr_r.hold || (lr_r.ext && (mr_r.st != sac_pkg::M_CONV));
	assign busy_o           = ext_view ? fr_r.busy
		: (mr_r.st != sac_pkg::M_CONV);
	assign busy_oe_o        = ext_view ? ~cs_n_i : 1'b1;
	assign mux_o            = lr_r.mux;
	assign acquire_o        = lr_r.acquire;
	assign hold_o           = lr_r.hold | (mr_r.st == sac_pkg::M_CONV);
	assign dac_code_o       = (mr_r.st == sac_pkg::M_CONV) ? mr_r.trial : lr_r.trial;
	// no wake-up wait is needed, so power-down simply follows converter activity
	assign low_power_o      = lr_r.pd && !lr_r.hold && !lr_r.acquire &&
		(mr_r.st == sac_pkg::M_IDLE);
	assign ext_clock_mode_o = lr_r.ext;

endmodule

// ==== bench/sac_serial_ctrl_monitor.sv ====
// concurrent checks on the serial control block ports
module sac_serial_ctrl_monitor (
	input wire logic              mclk_i,
	input wire logic              rst_i,
	input wire logic              serial_clock_i,
	input wire logic              cs_n_i,
	input wire logic              dout_oe_o,
	input wire logic              busy_o,
	input wire logic              busy_oe_o,
	input wire sac_pkg::sac_mux_t mux_o,
	input wire logic              acquire_o,
	input wire logic              hold_o,
	input wire logic              low_power_o,
	input wire logic              ext_clock_mode_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************************
	// port relations
	// ************************************************************
	a_dout_follow_cs: assert property (@(posedge mclk_i) disable iff (rst_i)
		dout_oe_o == !cs_n_i) else $error("dout enable does not follow chip select");
	a_busy_float_ext: assert property (@(posedge mclk_i) disable iff (rst_i)
		cs_n_i && ext_clock_mode_o && !hold_o |-> !busy_oe_o) else $error("busy driven");
	a_ext_busy_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		!cs_n_i && ext_clock_mode_o && !hold_o |-> !busy_o) else $error("busy high when idle");
	// hold guards against an internal end of conversion seen on a late edge
	a_busy_pulse_one: assert property (@(posedge serial_clock_i) disable iff (rst_i)
		$rose(busy_o) && hold_o |=> !busy_o) else $error("busy pulse longer than one clock");
	a_hold_after_acq: assert property (@(posedge serial_clock_i) disable iff (rst_i)
		$rose(hold_o) |-> $past(acquire_o)) else $error("hold without acquisition");
	a_acq_hold_excl: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(acquire_o && hold_o)) else $error("acquire and hold together");
	a_lp_when_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		low_power_o |-> !acquire_o && !hold_o) else $error("low power while working");
	a_mux_single_com: assert property (@(posedge mclk_i) disable iff (rst_i)
		mux_o.com_neg |-> mux_o.neg == 4'h0 && $onehot(mux_o.pos)) else $error("bad single");
	a_mux_diff_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
		mux_o.neg != 4'h0 |-> !mux_o.com_neg && $onehot(mux_o.neg) && $onehot(mux_o.pos)
		&& (|(mux_o.pos & 4'h3)) == (|(mux_o.neg & 4'h3))) else $error("bad pair");
endmodule

bind sac_serial_ctrl sac_serial_ctrl_monitor u_mon (
	.mclk_i, .rst_i, .serial_clock_i, .cs_n_i, .dout_oe_o, .busy_o, .busy_oe_o, .mux_o,
	.acquire_o, .hold_o, .low_power_o, .ext_clock_mode_o
);

// ==== bench/sac_host_model.sv ====
// host serial port model that frames control words and collects dout and busy
module sac_host_model (
	output logic      serial_clock_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i,
	input  wire logic busy_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// framing
	// ************************************************************
	logic [1:32] dv;
	logic [1:32] bv;

	initial begin
		serial_clock_o = 1'b0;
		cs_n_o = 1'b1;
		din_o = 1'b0;
	end

	// n clocks of 80 ns under chip select; word after ld zeros, din low after it
	task automatic frame(input logic [7:0] w, input int ld, input int n);
		cs_n_o = 1'b0;
		for (int i = 1; i <= n; i++) begin
			din_o = (i > ld && i <= ld + 8) ? w[ld + 8 - i] : 1'b0;
			#40 serial_clock_o = 1'b1;
			dv[i] = dout_i;
			bv[i] = busy_i;
			#40 serial_clock_o = 1'b0;
			// the link clock is fast, so acquisition is stretched with the clock low
			if (i == ld + 5)
				#1700;
		end
	endtask

	// released: din flips so a stale level is never mistaken for a driven one
	task automatic idle(input int n);
		cs_n_o = 1'b1;
		din_o = ~din_o;
		repeat (n) begin
			#40 serial_clock_o = 1'b1;
			#40 serial_clock_o = 1'b0;
		end
	endtask
endmodule

// ==== bench/sac_serial_ctrl_test.sv ====
// self-checking bench for the converter serial control block
module sac_serial_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************************
	// design, host model and comparator
	// ************************************************************
	logic              mclk = 1'b0;
	logic              rst = 1'b1;
	logic              sclk, cs_n, din, dout, dout_oe, busy, busy_oe, acq, hold, lp, extm;
	logic [15:0]       dac;
	logic [15:0]       tgt = 16'h0000;
	sac_pkg::sac_mux_t mux;
	int                err_total = 0;
	int                num_checks = 0;
	logic [2:0]        cd [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
	logic [15:0]       tg [4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h7FFF};
	wire               dout_w = dout_oe ? dout : 1'bz;
	wire               busy_w = busy_oe ? busy : 1'bz;
	// ideal comparator: a trial code is kept while it does not exceed the input
	wire               cmp = (dac <= tgt);

	always #12.5 mclk = ~mclk;

	sac_serial_ctrl uut (
		.mclk_i(mclk), .rst_i(rst), .serial_clock_i(sclk), .cs_n_i(cs_n), .din_i(din),
		.comparator_i(cmp), .dout_o(dout), .dout_oe_o(dout_oe), .busy_o(busy),
		.busy_oe_o(busy_oe), .mux_o(mux), .acquire_o(acq), .hold_o(hold),
		.dac_code_o(dac), .low_power_o(lp), .ext_clock_mode_o(extm)
	);
	sac_host_model host (
		.serial_clock_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w), .busy_i(busy_w)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic sac_pkg::sac_mux_t exp_mux(input int k, input logic s);
		exp_mux.pos = 4'h1 << k;
		exp_mux.neg = s ? 4'h0 : 4'h1 << (k ^ 1);
		exp_mux.com_neg = s;
	endfunction

	task automatic xconv(input logic [7:0] w, input logic [15:0] t);
		tgt = t;
		host.frame(w, 0, 25);
		host.idle(0);
		chk(16'(host.bv[8+:3]), 16'h0002);
		chk(host.dv[10+:16], t ^ sac_pkg::SIGN_BIT);
		repeat (4) @(negedge mclk);
	endtask

	task automatic iwait(output int lo);
		int t;
		t = 0;
		lo = 0;
		while (busy_w !== 1'b0 && t < 40) begin
			@(negedge mclk);
			t++;
		end
		while (busy_w === 1'b0 && lo < 400) begin
			@(negedge mclk);
			lo++;
		end
	endtask

	initial begin
		logic [1:32] pr;
		logic [7:0]  w;
		int          lo;
		bit          ok;
		pr = '0;
		fork
			host.idle(10);
			begin
				repeat (16) @(posedge mclk);
				rst <= 1'b0;
			end
		join
		@(negedge mclk);
		chk(16'(extm), 16'h0001);
		chk(16'(busy_w === 1'bz), 16'h0001);
		for (int i = 0; i <= 8; i++) begin
			w = {1'b1, cd[i % 4], 1'b0, 1'(i < 4), sac_pkg::MODE_EXT};
			tgt = tg[i % 4];
			host.frame(w, 0, i == 8 ? 32 : 24);
			chk(16'(host.bv[8+:3]), 16'h0002);
			chk(16'(mux), 16'(exp_mux(i % 4, 1'(i < 4))));
			if (i > 0)
				chk({pr[10+:15], host.dv[1]}, tg[(i - 1) % 4] ^ sac_pkg::SIGN_BIT);
			pr = host.dv;
		end
		host.idle(0);
		chk(pr[10+:16], tg[0] ^ sac_pkg::SIGN_BIT);
		chk(16'(pr[26+:7]), 16'h0000);
		xconv(8'h94, 16'h1234);
		chk(16'(lp), 16'h0001);
		chk(16'(extm), 16'h0001);
		xconv(8'h97, 16'hABCD);
		chk(16'({extm, lp}), 16'h0002);
		xconv(8'hA6, 16'h5A5A);
		chk(16'(extm), 16'h0000);
		tgt = 16'h0F0F;
		host.frame(8'hE6, 0, 8);
		host.idle(0);
		chk(16'(busy_oe), 16'h0001);
		iwait(lo);
		chk(16'(lo inside {[1:320]}), 16'h0001);
		chk(16'(dout_w === 1'bz), 16'h0001);
		host.frame(8'h00, 0, 20);
		host.idle(0);
		ok = 1'b0;
		for (int k = 1; k <= 5; k++)
			if (host.dv[k+:16] === 16'h8F0F)
				ok = 1'b1;
		chk(16'(ok), 16'h0001);
		chk(16'(host.bv[1]), 16'h0001);
		host.frame(8'h94, 3, 11);
		host.idle(0);
		iwait(lo);
		chk(16'(lo inside {[1:320]}), 16'h0001);
		chk(16'(extm), 16'h0000);
		chk(16'(lp), 16'h0001);
		wrap_up();
	end

	// the whole run needs well under 100 us of simulated time
	initial begin
		#300us;
		err_total++;
		wrap_up();
	end
endmodule
